// [load_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module load_decoder
   import word_load_pkg::*;
(
   input wire logic [31:0] instr,
   input wire logic release6,
   output decoded_type dec
);
   logic [5:0] opc;
   logic [5:0] func;

   assign opc = instr[OPC_MSB -: 6];
   assign func = instr[FUNC_MSB -: 6];

   always_comb begin
      dec.kind = K_NONE;
      dec.avail = 1'b1;
      dec.dest_reg = instr[RT_MSB -: 5];
      dec.offset = {{48{instr[15]}}, instr[15:0]};
      if (opc == OP_SIGNED_WORD) begin
         dec.kind = K_SIGNED_WORD;
      end else if (opc == OP_FP_WORD) begin
         dec.kind = K_FP_WORD;
      end else if (opc == OP_CP2_WORD && !release6) begin
         dec.kind = K_CP2_WORD;
      end else if (opc == OP_COPROC_TWO && instr[BASE_MSB -: 5] == SUB_CP2_WORD && release6) begin
         dec.kind = K_CP2_WORD;
         dec.offset = {{53{instr[10]}}, instr[10:0]};
      end else if (opc == OP_EXT_GROUP && func == FN_KERNEL_USER && !instr[EXT_ZERO_BIT]) begin
         dec.kind = K_KERNEL_USER;
         dec.offset = {{55{instr[EXT_OFS_MSB]}}, instr[EXT_OFS_MSB -: 9]};
      end else if (opc == OP_LEFT_MERGE) begin
         dec.kind = K_LEFT_MERGE;
         dec.avail = !release6;
      end else if (opc == OP_FP_EXTENDED && func == FN_INDEXED_DW) begin
         dec.kind = K_INDEXED_DW;
         dec.avail = !release6;
         dec.dest_reg = instr[FD_MSB -: 5];
      end
   end
endmodule
`default_nettype wire

// [wl_tb_pkg.sv]
`default_nettype none
package wl_tb_pkg;
   localparam logic [63:0] PA_OFS = 64'h0000_0001_0000_0000;
   // Stored doubleword depends on address bits 10..3 only
   function automatic logic [63:0] mem_dw(input logic [63:0] p);
      mem_dw = 64'hf1e2_d3c4_b5a6_9788 ^ {8{p[10:3]}};
   endfunction
endpackage
`default_nettype wire

// [word_lane_merge.sv]
`timescale 1ns/1ps
`default_nettype none
module word_lane_merge
   import word_load_pkg::*;
(
   input wire logic [63:0] dw,
   input wire logic [2:0] vaddr_low,
   input wire logic core_be,
   input wire logic [31:0] old_low,
   output logic [31:0] lane_word,
   output logic [31:0] merged_word
);
   logic [2:0] byte_sel;
   logic [63:0] shifted;
   logic [1:0] merge_byte;
   logic [31:0] merge_src;
   logic [4:0] merge_shift;
   logic [31:0] keep_mask;

   always_comb begin
      byte_sel = vaddr_low ^ {core_be, 2'b00};
      shifted = dw >> {byte_sel, 3'b000};
      lane_word = shifted[31:0];
      merge_byte = vaddr_low[1:0] ^ {2{core_be}};
      merge_src = pick_word(dw, vaddr_low[2] ^ core_be);
      merge_shift = 5'h18 - {merge_byte, 3'b000};
      keep_mask = (32'h0000_0001 << merge_shift) - 32'h0000_0001;
      merged_word = (merge_src << merge_shift) | (old_low & keep_mask);
   end
endmodule
`default_nettype wire

// [word_load_pkg.sv]
// Notes on behaviour
// - Indexed doubleword address is base plus index, aligned.
// - Indexed load reads two words, concatenated raw.
// - Indexed load never raises address error.
// - Signed word load decodes opcode, sign-extends word.
// - Word address is base plus sign-extended offset.
// - Before Release 6, misaligned word load traps.
// - Release 6 completes misaligned loads inside doubleword; with big-endian core the lane is offset xor 4, right only when aligned.
// - Lane chosen by address bits and byte order.
// - Signed word load exceptions: translation, bus, alignment, watch.
// - Floating word load fills low register word.
// - Floating and coprocessor loads add unusable, reserved exceptions.
// - Coprocessor two load sign-extends into low word.
// - Coprocessor two load encoding differs by release.
// - Kernel user load decodes extended group, 9-bit offset.
// - Kernel user load translates through user mapping.
// - Kernel user load needs flag, privilege, segment.
// - Kernel user load adds reserved and unusable exceptions.
// - Left merge load exists only before Release 6.
// - Left merge keeps low bytes of destination.
// - Left merge replicates word bit 31 upward.
// - Left merge bytes depend on offset and order.
// - Left merge may raise bus and translation exceptions, never alignment.
`default_nettype none
package word_load_pkg;

   localparam int XLEN = 64;
   localparam int OPC_MSB = 31;
   localparam int BASE_MSB = 25;
   localparam int RT_MSB = 20;
   localparam int R6_BASE_MSB = 15;
   localparam int FD_MSB = 10;
   localparam int FUNC_MSB = 5;
   localparam int EXT_ZERO_BIT = 6;
   localparam int EXT_OFS_MSB = 15;
   localparam logic [5:0] OP_SIGNED_WORD = 6'h23;
   localparam logic [5:0] OP_FP_WORD = 6'h31;
   localparam logic [5:0] OP_CP2_WORD = 6'h32;
   localparam logic [5:0] OP_COPROC_TWO = 6'h12;
   localparam logic [4:0] SUB_CP2_WORD = 5'h0a;
   localparam logic [5:0] OP_EXT_GROUP = 6'h1f;
   localparam logic [5:0] FN_KERNEL_USER = 6'h2f;
   localparam logic [5:0] OP_LEFT_MERGE = 6'h22;
   localparam logic [5:0] OP_FP_EXTENDED = 6'h13;
   localparam logic [5:0] FN_INDEXED_DW = 6'h01;
   localparam logic [2:0] DW_ALIGN_MASK = 3'h0;
   localparam logic [2:0] WORD_LANE_LIMIT = 3'h4;
   localparam logic [63:0] DW_SECOND_WORD = 64'h0000_0000_0000_0004;
   localparam logic [63:0] WORD_STEP = 64'h0000_0000_0000_0004;

   typedef enum logic [2:0] {
      K_NONE, K_SIGNED_WORD, K_FP_WORD, K_CP2_WORD, K_KERNEL_USER, K_LEFT_MERGE, K_INDEXED_DW
   } load_kind_type;
   typedef enum logic [1:0] {T_GPR, T_FPR, T_CP2} wb_target_type;
   typedef enum logic [3:0] {
      EXC_NONE, EXC_ADDR_ERR, EXC_TLB_REFILL, EXC_TLB_INVALID, EXC_BUS_ERR, EXC_WATCH,
      EXC_RSVD_INSTR, EXC_COP_UNUSABLE
   } exc_code_type;

   typedef struct packed {
      load_kind_type kind;
      logic avail;
      logic [4:0] dest_reg;
      logic [63:0] offset;
   } decoded_type;
   typedef struct packed {
      logic release6;
      logic core_byte_order_flag;
      logic swapped_byte_order_flag;
      logic enhanced_virtual_addressing_flag;
      logic cop0_access_enabled;
      logic cop1_enabled;
      logic coprocessor_two_opcode_enabled;
   } cfg_type;
   typedef struct packed {
      logic [31:0] instr;
      logic [63:0] base_val;
      logic [63:0] index_val;
      logic [63:0] dest_old;
   } issue_type;
   typedef struct packed {
      logic [63:0] vaddr;
      logic user_map;
   } xlate_req_type;
   typedef struct packed {
      logic [63:0] paddr;
      logic refill;
      logic invalid;
      logic watch;
      logic seg_user_ok;
   } xlate_rsp_type;
   typedef struct packed {
      logic [63:0] paddr;
      logic [63:0] vaddr;
   } mem_req_type;
   typedef struct packed {
      logic [63:0] data;
      logic bus_err;
   } mem_rsp_type;
   typedef struct packed {
      wb_target_type target;
      logic [4:0] reg_num;
      logic [63:0] data;
   } wb_type;

   function automatic logic [63:0] sext32(input logic [31:0] w);
      sext32 = {{32{w[31]}}, w};
   endfunction

   function automatic logic [31:0] pick_word(input logic [63:0] dw, input logic upper);
      pick_word = upper ? dw[63:32] : dw[31:0];
   endfunction

endpackage
`default_nettype wire

// [word_load_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module word_load_unit
   import word_load_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire cfg_type cfg,
   input wire logic issue_valid,
   output logic issue_ready,
   input wire issue_type issue,
   output logic xlate_valid,
   output xlate_req_type xlate_req,
   input wire logic xlate_ack,
   input wire xlate_rsp_type xlate_rsp,
   output logic mem_valid,
   output mem_req_type mem_req,
   input wire logic mem_ack,
   input wire mem_rsp_type mem_rsp,
   output logic wb_valid,
   output wb_type wb,
   output logic exc_valid,
   output exc_code_type exc_code
);
   typedef enum logic [1:0] {S_IDLE, S_XLATE, S_READ1, S_READ2} state_type;

   state_type state, next_state;
   load_kind_type kind, next_kind;
   logic [4:0] dest, next_dest;
   logic [31:0] old_low, next_old_low;
   logic [31:0] lsw, next_lsw;
   xlate_req_type next_xlate_req;
   mem_req_type next_mem_req;
   logic next_wb_valid, next_exc_valid;
   wb_type next_wb;
   exc_code_type next_exc_code;
   decoded_type dec;
   logic issue_fire;
   logic [63:0] index_sum;
   logic [63:0] issue_ea;
   exc_code_type issue_exc;
   logic [2:0] addr_flip;
   logic [31:0] lane_word, merged_word;
   wb_target_type target;

   load_decoder u_dec (
      .instr(issue.instr),
      .release6(cfg.release6),
      .dec(dec)
   );

   word_lane_merge u_lane (
      .dw(mem_rsp.data),
      .vaddr_low(mem_req.vaddr[2:0]),
      .core_be(cfg.core_byte_order_flag),
      .old_low(old_low),
      .lane_word(lane_word),
      .merged_word(merged_word)
   );

   assign issue_ready = (state == S_IDLE);
   assign issue_fire = issue_valid && issue_ready;
   assign xlate_valid = (state == S_XLATE);
   assign mem_valid = (state == S_READ1) || (state == S_READ2);

   // Address forming and checks made before translation
   always_comb begin
      index_sum = issue.base_val + issue.index_val;
      if (dec.kind == K_INDEXED_DW) begin
         issue_ea = {index_sum[63:3], DW_ALIGN_MASK};
      end else begin
         issue_ea = issue.base_val + dec.offset;
      end
      issue_exc = EXC_NONE;
      if (dec.kind == K_NONE || !dec.avail) begin
         issue_exc = EXC_RSVD_INSTR;
      end else if (dec.kind == K_KERNEL_USER && !cfg.enhanced_virtual_addressing_flag) begin
         issue_exc = EXC_RSVD_INSTR;
      end else if (dec.kind == K_KERNEL_USER && !cfg.cop0_access_enabled) begin
         issue_exc = EXC_COP_UNUSABLE;
      end else if ((dec.kind == K_FP_WORD || dec.kind == K_INDEXED_DW) && !cfg.cop1_enabled) begin
         issue_exc = EXC_COP_UNUSABLE;
      end else if (dec.kind == K_CP2_WORD && !cfg.coprocessor_two_opcode_enabled) begin
         issue_exc = EXC_COP_UNUSABLE;
      end else if (dec.kind != K_LEFT_MERGE && dec.kind != K_INDEXED_DW) begin
         if (!cfg.release6 && issue_ea[1:0] != 2'b00) begin
            issue_exc = EXC_ADDR_ERR;
         end else if (cfg.release6 && issue_ea[2:0] > WORD_LANE_LIMIT) begin
            issue_exc = EXC_ADDR_ERR;
         end
      end
   end

   always_comb begin
      case (kind)
         K_FP_WORD, K_INDEXED_DW: target = T_FPR;
         K_CP2_WORD: target = T_CP2;
         default: target = T_GPR;
      endcase
   end

   // Physical lane adjustment by byte order
   always_comb begin
      case (kind)
         K_INDEXED_DW: addr_flip = {cfg.core_byte_order_flag ^ cfg.swapped_byte_order_flag, 2'b00};
         K_LEFT_MERGE: addr_flip = {3{cfg.swapped_byte_order_flag}};
         default: addr_flip = {cfg.swapped_byte_order_flag, 2'b00};
      endcase
   end

   always_comb begin
      next_state = state;
      next_kind = kind;
      next_dest = dest;
      next_old_low = old_low;
      next_lsw = lsw;
      next_xlate_req = xlate_req;
      next_mem_req = mem_req;
      next_wb_valid = 1'b0;
      next_exc_valid = 1'b0;
      next_wb = wb;
      next_exc_code = exc_code;
      case (state)
         S_IDLE: begin
            if (issue_fire) begin
               next_kind = dec.kind;
               next_dest = dec.dest_reg;
               next_old_low = issue.dest_old[31:0];
               next_xlate_req.vaddr = issue_ea;
               next_xlate_req.user_map = (dec.kind == K_KERNEL_USER);
               if (issue_exc != EXC_NONE) begin
                  next_exc_valid = 1'b1;
                  next_exc_code = issue_exc;
               end else begin
                  next_state = S_XLATE;
               end
            end
         end
         S_XLATE: begin
            if (xlate_ack) begin
               next_exc_valid = 1'b1;
               next_state = S_IDLE;
               if (xlate_rsp.refill) begin
                  next_exc_code = EXC_TLB_REFILL;
               end else if (xlate_rsp.invalid) begin
                  next_exc_code = EXC_TLB_INVALID;
               end else if (kind == K_KERNEL_USER && !xlate_rsp.seg_user_ok) begin
                  next_exc_code = EXC_ADDR_ERR;
               end else if (xlate_rsp.watch) begin
                  next_exc_code = EXC_WATCH;
               end else begin
                  next_exc_valid = 1'b0;
                  next_state = S_READ1;
                  next_mem_req.paddr = xlate_rsp.paddr ^ {61'h0, addr_flip};
                  next_mem_req.vaddr = xlate_req.vaddr;
               end
            end
         end
         S_READ1: begin
            if (mem_ack) begin
               next_state = S_IDLE;
               if (mem_rsp.bus_err) begin
                  next_exc_valid = 1'b1;
                  next_exc_code = EXC_BUS_ERR;
               end else if (kind == K_INDEXED_DW) begin
                  next_lsw = pick_word(mem_rsp.data, mem_req.paddr[2]);
                  next_mem_req.paddr = mem_req.paddr ^ DW_SECOND_WORD;
                  next_mem_req.vaddr = mem_req.vaddr + WORD_STEP;
                  next_state = S_READ2;
               end else begin
                  next_wb_valid = 1'b1;
                  next_wb.target = target;
                  next_wb.reg_num = dest;
                  case (kind)
                     K_FP_WORD: next_wb.data = {32'h0000_0000, lane_word};
                     K_LEFT_MERGE: next_wb.data = sext32(merged_word);
                     K_CP2_WORD: next_wb.data = sext32(lane_word);
                     default: next_wb.data = sext32(lane_word);
                  endcase
               end
            end
         end
         S_READ2: begin
            if (mem_ack) begin
               next_state = S_IDLE;
               if (mem_rsp.bus_err) begin
                  next_exc_valid = 1'b1;
                  next_exc_code = EXC_BUS_ERR;
               end else begin
                  next_wb_valid = 1'b1;
                  next_wb.target = T_FPR;
                  next_wb.reg_num = dest;
                  next_wb.data = {pick_word(mem_rsp.data, mem_req.paddr[2]), lsw};
               end
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= S_IDLE;
         kind <= K_NONE;
         dest <= 5'h00;
         old_low <= 32'h0000_0000;
         lsw <= 32'h0000_0000;
         xlate_req <= '0;
         mem_req <= '0;
         wb_valid <= 1'b0;
         exc_valid <= 1'b0;
         wb <= '0;
         exc_code <= EXC_NONE;
      end else begin
         state <= next_state;
         kind <= next_kind;
         dest <= next_dest;
         old_low <= next_old_low;
         lsw <= next_lsw;
         xlate_req <= next_xlate_req;
         mem_req <= next_mem_req;
         wb_valid <= next_wb_valid;
         exc_valid <= next_exc_valid;
         wb <= next_wb;
         exc_code <= next_exc_code;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   sequence s_first_read_ok;
      state == S_READ1 && mem_ack && !mem_rsp.bus_err && kind == K_INDEXED_DW;
   endsequence

   sequence s_read_fault;
      mem_valid && mem_ack && mem_rsp.bus_err;
   endsequence

   sequence s_misaligned_issue;
      issue_fire && !cfg.release6 && dec.kind == K_SIGNED_WORD && issue_ea[1:0] != 2'b00;
   endsequence

   a_no_commit_on_exc:
   assert property (exc_valid |-> !wb_valid)
      else $error("writeback issued together with an exception");

   a_align_trap:
   assert property (s_misaligned_issue |=> exc_valid && exc_code == EXC_ADDR_ERR && !xlate_valid)
      else $error("misaligned word load did not trap");

   a_indexed_no_addr_err:
   assert property (exc_valid && kind == K_INDEXED_DW |-> exc_code != EXC_ADDR_ERR)
      else $error("indexed doubleword load raised address error");

   a_indexed_aligned:
   assert property (xlate_valid && kind == K_INDEXED_DW |-> xlate_req.vaddr[2:0] == DW_ALIGN_MASK)
      else $error("indexed doubleword address not aligned");

   a_second_read_addr:
   assert property (s_first_read_ok |=> mem_valid && mem_req.paddr == ($past(mem_req.paddr) ^ DW_SECOND_WORD)
                    && mem_req.vaddr == $past(mem_req.vaddr) + WORD_STEP)
      else $error("second word read address wrong");

   a_signed_word_sext:
   assert property (wb_valid && (kind == K_SIGNED_WORD || kind == K_KERNEL_USER || kind == K_CP2_WORD)
                    |-> wb.data[63:32] == {32{wb.data[31]}})
      else $error("word load result not sign-extended");

   a_left_merge_sign:
   assert property (wb_valid && kind == K_LEFT_MERGE |-> wb.data[63:32] == {32{wb.data[31]}})
      else $error("left merge upper word not replicated");

   a_eva_absent:
   assert property (issue_fire && dec.kind == K_KERNEL_USER && !cfg.enhanced_virtual_addressing_flag
                    |=> exc_valid && exc_code == EXC_RSVD_INSTR)
      else $error("kernel user load accepted without the feature");

   a_left_merge_gone:
   assert property (issue_fire && dec.kind == K_LEFT_MERGE && cfg.release6 |=> exc_valid
                    && exc_code == EXC_RSVD_INSTR)
      else $error("left merge load accepted in Release 6");

   a_bus_fault:
   assert property (s_read_fault |=> exc_valid && exc_code == EXC_BUS_ERR && !wb_valid && issue_ready)
      else $error("bus error not reported");

   a_user_mapping:
   assert property (xlate_valid |-> xlate_req.user_map == (kind == K_KERNEL_USER))
      else $error("user mapping request mismatched");

   a_fp_upper_zero:
   assert property (wb_valid && kind == K_FP_WORD |-> wb.target == T_FPR && wb.data[63:32] == 32'h0000_0000)
      else $error("floating word load upper word not cleared");

   a_r6_misalign_trap:
   assert property (issue_fire && cfg.release6 && dec.kind == K_SIGNED_WORD && issue_ea[2:0] > WORD_LANE_LIMIT
                    |=> exc_valid && exc_code == EXC_ADDR_ERR && !xlate_valid)
      else $error("word load misaligned beyond the doubleword not trapped");

endmodule
`default_nettype wire

// [word_load_unit_test.sv]
`timescale 1ns/1ps
`default_nettype none
module word_load_unit_test
   import word_load_pkg::*, wl_tb_pkg::*;
;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   cfg_type cfg = '0;
   logic issue_valid = 1'b0;
   issue_type issue = '0;
   logic issue_ready, xlate_valid, xlate_ack, mem_valid, mem_ack, wb_valid, exc_valid;
   xlate_req_type xlate_req;
   xlate_rsp_type xlate_rsp;
   mem_req_type mem_req;
   mem_rsp_type mem_rsp;
   wb_type wb;
   exc_code_type exc_code;
   logic [1:0] dly = 2'h0;
   logic [4:0] flt = 5'h10;
   cfg_type c;
   logic [1:0] d;
   logic [4:0] f;
   logic [63:0] pa [2];
   logic [63:0] va [2];
   logic umap, wbs, exs;
   int num_errors = 0;
   int total_checks = 0;

   always #50 clk_sys = ~clk_sys;

   word_load_unit dut (.clk_sys(clk_sys), .srst(srst), .cfg(cfg), .issue_valid(issue_valid),
      .issue_ready(issue_ready), .issue(issue), .xlate_valid(xlate_valid), .xlate_req(xlate_req),
      .xlate_ack(xlate_ack), .xlate_rsp(xlate_rsp), .mem_valid(mem_valid), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rsp(mem_rsp), .wb_valid(wb_valid), .wb(wb), .exc_valid(exc_valid),
      .exc_code(exc_code));
   xlate_mem_model pm (.clk_sys(clk_sys), .srst(srst), .dly(dly), .flt(flt), .xlate_valid(xlate_valid),
      .xlate_req(xlate_req), .xlate_ack(xlate_ack), .xlate_rsp(xlate_rsp), .mem_valid(mem_valid),
      .mem_req(mem_req), .mem_ack(mem_ack), .mem_rsp(mem_rsp));

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Issues one load and watches the far side until the result pulse
   task automatic run(input logic [31:0] ins, input logic [63:0] b, input logic [63:0] x,
      input logic [63:0] o);
      int n;
      bit done;
      done = 0;
      n = 0;
      umap = 1'b0;
      @(posedge clk_sys);
      cfg <= c;
      dly <= d;
      flt <= f;
      issue_valid <= 1'b1;
      issue <= '{ins, b, x, o};
      @(posedge clk_sys);
      issue_valid <= 1'b0;
      for (int k = 0; k < 60 && !done; k++) begin
         @(negedge clk_sys);
         if (xlate_valid) umap = xlate_req.user_map;
         if (mem_valid && mem_ack && n < 2) begin
            pa[n] = mem_req.paddr;
            va[n] = mem_req.vaddr;
            n++;
         end
         wbs = wb_valid;
         exs = exc_valid;
         done = wbs || exs;
      end
      if (!done) begin
         num_errors++;
         $display("MISMATCH result_pulse expected 1 seen 0");
         summarize();
      end
   endtask

   task automatic expw(input wb_target_type t, input logic [4:0] r, input logic [63:0] dd);
      chk("wb_dest", {56'h0, 1'b1, t, r}, {56'h0, wbs, wb.target, wb.reg_num});
      chk("wb_data", dd, wb.data);
   endtask

   task automatic expx(input exc_code_type e);
      chk("exc", {58'h0, 2'b01, e}, {58'h0, wbs, exs, exc_code});
   endtask

   task automatic fx(input logic [31:0] ins, input logic [63:0] b, input logic [4:0] fl,
      input exc_code_type e);
      f = fl;
      run(ins, b, 64'h0, 64'h0);
      expx(e);
      f = 5'h10;
   endtask

   function automatic logic [31:0] enc(input logic [5:0] op, input logic [15:0] off);
      enc = {op, 5'h03, 5'h07, off};
   endfunction

   function automatic logic [63:0] sx(input logic [31:0] w);
      sx = {{32{w[31]}}, w};
   endfunction

   function automatic logic [31:0] lane(input logic [63:0] v, input logic be);
      logic [2:0] b;
      b = v[2:0] ^ {be, 2'b00};
      lane = 32'(mem_dw(v) >> (8 * b));
   endfunction

   task automatic t_signed();
      logic [63:0] v;
      for (int e = 0; e < 8; e++) begin
         c = cfg_type'(7'h0f);
         c.core_byte_order_flag = e[0];
         c.swapped_byte_order_flag = e[1];
         v = 64'h1000 | {53'h0, e[0], 7'h0, e[2], 2'b00};
         run(enc(6'h23, 16'hfff0), v + 64'h10, 64'h0, 64'h0);
         expw(T_GPR, 5'h07, sx(lane(v, e[0])));
         chk("paddr", (v ^ PA_OFS) ^ {61'h0, e[1], 2'b00}, pa[0]);
         chk("user_map", 64'h0, {63'h0, umap});
      end
   endtask

   task automatic t_align();
      logic [31:0] ins [4];
      ins[0] = enc(6'h23, 16'h0000);
      ins[1] = enc(6'h31, 16'h0000);
      ins[2] = enc(6'h32, 16'h0000);
      ins[3] = enc(6'h1f, 16'h002f);
      c = cfg_type'(7'h0f);
      for (int k = 0; k < 12; k++) begin
         fx(ins[k / 3], 64'h1000 + 64'(k % 3 + 1), 5'h10, EXC_ADDR_ERR);
      end
      c.release6 = 1'b1;
      run(ins[0], 64'h1002, 64'h0, 64'h0);
      expw(T_GPR, 5'h07, sx(lane(64'h1002, 1'b0)));
      fx(ins[0], 64'h1005, 5'h10, EXC_ADDR_ERR);
   endtask

   task automatic t_fpcp();
      logic [31:0] r6;
      r6 = {6'h12, 5'h0a, 5'h07, 5'h03, 11'h7fc};
      c = cfg_type'(7'h0f);
      run(enc(6'h31, 16'h0004), 64'h1400, 64'h0, 64'h0);
      expw(T_FPR, 5'h07, {32'h0, lane(64'h1404, 1'b0)});
      run(enc(6'h32, 16'h0004), 64'h1400, 64'h0, 64'h0);
      expw(T_CP2, 5'h07, sx(lane(64'h1404, 1'b0)));
      c.release6 = 1'b1;
      run(r6, 64'h1008, 64'h0, 64'h0);
      expw(T_CP2, 5'h07, sx(lane(64'h1004, 1'b0)));
      c.coprocessor_two_opcode_enabled = 1'b0;
      fx(r6, 64'h1008, 5'h10, EXC_COP_UNUSABLE);
      fx(enc(6'h32, 16'h0004), 64'h1400, 5'h10, EXC_RSVD_INSTR);
      c = cfg_type'(7'h0d);
      fx(enc(6'h31, 16'h0004), 64'h1400, 5'h10, EXC_COP_UNUSABLE);
   endtask

   task automatic t_kern();
      logic [31:0] ins;
      ins = enc(6'h1f, {9'h1f8, 1'b0, 6'h2f});
      c = cfg_type'(7'h0f);
      run(ins, 64'h1008, 64'h0, 64'h0);
      expw(T_GPR, 5'h07, sx(lane(64'h1000, 1'b0)));
      chk("user_map", 64'h1, {63'h0, umap});
      fx(ins, 64'h1008, 5'h00, EXC_ADDR_ERR);
      fx(ins | 32'h0000_0040, 64'h1008, 5'h10, EXC_RSVD_INSTR);
      c = cfg_type'(7'h07);
      fx(ins, 64'h1008, 5'h10, EXC_RSVD_INSTR);
      c = cfg_type'(7'h0b);
      fx(ins, 64'h1008, 5'h10, EXC_COP_UNUSABLE);
   endtask

   task automatic t_left();
      logic [63:0] v, w, t;
      logic [63:0] o;
      int n;
      o = 64'h0000_0000_a1b2_c3d4;
      for (int e = 0; e < 16; e++) begin
         c = cfg_type'(7'h0f);
         c.core_byte_order_flag = e[2];
         c.swapped_byte_order_flag = e[3];
         v = 64'h1004 + 64'(e[1:0]);
         w = mem_dw(v) >> (32 * (v[2] ^ e[2]));
         n = e[2] ? 4 - e[1:0] : e[1:0] + 1;
         t = (w << (8 * (4 - n))) | (o & ((64'h1 << (8 * (4 - n))) - 64'h1));
         run(enc(6'h22, 16'h0000), v, 64'h0, o);
         expw(T_GPR, 5'h07, sx(t[31:0]));
         chk("paddr_low", {61'h0, v[2:0] ^ {3{e[3]}}}, {61'h0, pa[0][2:0]});
      end
      c.release6 = 1'b1;
      fx(enc(6'h22, 16'h0000), 64'h1004, 5'h10, EXC_RSVD_INSTR);
   endtask

   task automatic t_index();
      logic [63:0] p, w;
      for (int e = 0; e < 4; e++) begin
         c = cfg_type'(7'h0f);
         c.core_byte_order_flag = e[0];
         c.swapped_byte_order_flag = e[1];
         run(enc(6'h13, 16'h0241), 64'h1000, 64'h0405, 64'h0);
         p = (64'h1400 ^ PA_OFS) ^ {61'h0, e[0] ^ e[1], 2'b00};
         w = mem_dw(p);
         chk("vaddr1", 64'h1400, va[0]);
         chk("paddr1", p, pa[0]);
         chk("paddr2", p ^ 64'h4, pa[1]);
         chk("vaddr2", 64'h1404, va[1]);
         expw(T_FPR, 5'h09, p[2] ? {w[31:0], w[63:32]} : w);
      end
      c.release6 = 1'b1;
      fx(enc(6'h13, 16'h0241), 64'h1000, 5'h10, EXC_RSVD_INSTR);
      c = cfg_type'(7'h0d);
      fx(enc(6'h13, 16'h0241), 64'h1000, 5'h10, EXC_COP_UNUSABLE);
   endtask

   task automatic t_fault();
      c = cfg_type'(7'h0f);
      d = 2'h3;
      fx(enc(6'h23, 16'h0000), 64'h1000, 5'h13, EXC_TLB_REFILL);
      fx(enc(6'h23, 16'h0000), 64'h1000, 5'h12, EXC_TLB_INVALID);
      fx(enc(6'h23, 16'h0000), 64'h1000, 5'h14, EXC_WATCH);
      fx(enc(6'h23, 16'h0000), 64'h1000, 5'h18, EXC_BUS_ERR);
      fx(enc(6'h22, 16'h0000), 64'h1000, 5'h18, EXC_BUS_ERR);
      fx(enc(6'h31, 16'h0000), 64'h1000, 5'h12, EXC_TLB_INVALID);
      fx(enc(6'h13, 16'h0241), 64'h1000, 5'h14, EXC_WATCH);
      fx(enc(6'h3f, 16'h0000), 64'h1000, 5'h10, EXC_RSVD_INSTR);
      d = 2'h0;
   endtask

   initial begin
      c = cfg_type'(7'h0f);
      d = 2'h0;
      f = 5'h10;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      chk("idle", {56'h0, 4'b1000, EXC_NONE}, {56'h0, issue_ready, wb_valid, exc_valid, mem_valid, exc_code});
      t_signed();
      $display("test signed word done");
      t_align();
      $display("test alignment done");
      t_fpcp();
      $display("test fp and coproc2 done");
      t_kern();
      $display("test kernel user load done");
      t_left();
      $display("test left merge done");
      t_index();
      $display("test indexed doubleword done");
      t_fault();
      $display("test faults done");
      summarize();
   end
endmodule
`default_nettype wire

// [xlate_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module xlate_mem_model
   import word_load_pkg::*, wl_tb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [1:0] dly,
   input wire logic [4:0] flt,
   input wire logic xlate_valid,
   input wire xlate_req_type xlate_req,
   output logic xlate_ack,
   output xlate_rsp_type xlate_rsp,
   input wire logic mem_valid,
   input wire mem_req_type mem_req,
   output logic mem_ack,
   output mem_rsp_type mem_rsp
);
   logic [1:0] xcnt;
   logic [1:0] mcnt;
   // Answer lines toggle between answers so a stale value never passes
   always_ff @(posedge clk_sys) begin
      xlate_ack <= 1'b0;
      mem_ack <= 1'b0;
      xlate_rsp <= ~xlate_rsp;
      mem_rsp <= ~mem_rsp;
      if (srst) begin
         xcnt <= 2'h0;
         mcnt <= 2'h0;
         xlate_rsp <= '0;
         mem_rsp <= '0;
      end else begin
         if (xlate_valid && !xlate_ack) begin
            xcnt <= xcnt + 2'h1;
            if (xcnt == dly) begin
               xcnt <= 2'h0;
               xlate_ack <= 1'b1;
               xlate_rsp <= '{xlate_req.vaddr ^ PA_OFS, flt[0], flt[1], flt[2], flt[4]};
            end
         end
         if (mem_valid && !mem_ack) begin
            mcnt <= mcnt + 2'h1;
            if (mcnt == dly) begin
               mcnt <= 2'h0;
               mem_ack <= 1'b1;
               mem_rsp <= '{mem_dw(mem_req.paddr), flt[3]};
            end
         end
      end
   end
endmodule
`default_nettype wire
